/* verilog/srta_adapter.sv */
/*
  Stream ready timing adapter with its beat buffer and register slave.
  Assumes one clock and reset shared by both stream partners and the bus.
*/
// Added by the designer: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "srta_params.svh"

module srta_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rstn,
  // Fill side
  input  wire logic                         wr_valid,
  output logic                              wr_ready,
  input  wire logic [WIDTH-1:0]             wr_data,
  // Drain side
  output logic                              rd_valid,
  input  wire logic                         rd_ready,
  output logic [WIDTH-1:0]                  rd_data,
  output logic [$clog2(DEPTH+1)-1:0]        level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wp_r, wp_nxt, rp_r, rp_nxt;
  logic [LW-1:0]    lvl_r, lvl_nxt;
  logic             push, pop;

  assign wr_ready = (lvl_r != LW'(DEPTH));
  assign rd_valid = (lvl_r != '0);
  assign rd_data  = mem_r[rp_r];
  assign level    = lvl_r;
  assign push     = wr_valid & wr_ready;
  assign pop      = rd_valid & rd_ready;

  always_comb begin
    wp_nxt  = wp_r;
    rp_nxt  = rp_r;
    lvl_nxt = lvl_r;
    if (push) begin
      wp_nxt = (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + PW'(1);
    end
    if (pop) begin
      rp_nxt = (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + PW'(1);
    end
    if (push && !pop) begin
      lvl_nxt = lvl_r + LW'(1);
    end else if (pop && !push) begin
      lvl_nxt = lvl_r - LW'(1);
    end
  end

  // Oldest beat leaves first; reset drops contents
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      lvl_r <= '0;
    end else begin
      wp_r  <= wp_nxt;
      rp_r  <= rp_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= wr_data;
    end
  end

  fifo_no_ovf_a : assert property (@(posedge core_clk) disable iff (!rstn)
    lvl_r == LW'(DEPTH) |-> !push)
    else $error("fifo written while full");
endmodule

module srta_adapter #(
  // Ready option per port
  parameter bit IN_HAS_READY  = 1'b1,
  parameter bit OUT_HAS_READY = 1'b1,
  parameter int IN_RL         = 2,
  parameter int OUT_RL        = 1
) (
  // Clock and reset
  input  wire logic                       core_clk,
  input  wire logic                       rstn,
  // Upstream stream (adapter sink port)
  input  wire logic                       in_valid,
  output logic                            in_ready,
  input  wire srta_pkg::srta_beat_t       in_beat,
  // Downstream stream (adapter source port)
  output logic                            out_valid,
  input  wire logic                       out_ready,
  output srta_pkg::srta_beat_t            out_beat,
  // Data loss indication
  output logic                            loss_err,
  // Register slave
  input  wire logic [`SRTA_ADDR_W-1:0]    avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest
);
  import srta_pkg::*;

  localparam bit BOTH   = IN_HAS_READY && OUT_HAS_READY;
  localparam bit BUFFER = BOTH && (OUT_RL < IN_RL);
  localparam int OH     = (OUT_RL > 0) ? OUT_RL : 1;
  localparam int IH     = (IN_RL > 0) ? IN_RL : 1;
  localparam int DIFF   = (OUT_RL > IN_RL) ? OUT_RL - IN_RL : 0;
  localparam int DH     = (DIFF > 0) ? DIFF : 1;

  // Ready history of the downstream sink
  logic [OH-1:0] ohist_r, ohist_nxt;
  logic          out_ok;
  logic          out_rdy_eff;

  // Downstream without ready always accepts
  assign out_rdy_eff = OUT_HAS_READY ? out_ready : 1'b1;
  // Beat may go out only if ready was seen OUT_RL cycles ago
  assign out_ok = (OUT_RL == 0) ? out_rdy_eff : ohist_r[OH-1];

  always_comb begin
    ohist_nxt = OH'({ohist_r, out_rdy_eff});
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ohist_r <= '0;
    end else begin
      ohist_r <= ohist_nxt;
    end
  end

  // Control and status state
  logic      err_en_r, err_en_nxt;
  logic      loss_st_r, loss_st_nxt;
  logic      loss_p_r, loss_p_nxt;
  srta_cnt_t loss_cnt_r, loss_cnt_nxt;
  logic      lost;
  srta_lvl_t lvl;

  generate
    if (BUFFER) begin : g_buf
      logic [IH-1:0]   ihist_r, ihist_nxt;
      logic [2:0]      resv;
      logic            in_rdy_c;
      logic            f_wr_ready;
      logic            f_rd_valid;
      srta_beat_t      f_rd_data;

      // Count grants whose beats may still arrive
      always_comb begin
        resv = '0;
        for (int i = 0; i < IH; i++) begin
          resv = resv + {2'h0, ihist_r[i]};
        end
      end
      // Grant only when every outstanding beat still fits
      assign in_rdy_c  = ({1'b0, lvl} + {1'b0, resv}) < 4'(`SRTA_FIFO_DEPTH);
      assign in_ready  = in_rdy_c;
      assign ihist_nxt = IH'({ihist_r, in_rdy_c});

      always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
          ihist_r <= '0;
        end else begin
          ihist_r <= ihist_nxt;
        end
      end

      srta_fifo #(
        .WIDTH ($bits(srta_beat_t)),
        .DEPTH (`SRTA_FIFO_DEPTH)
      ) u_fifo (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wr_valid (in_valid),
        .wr_ready (f_wr_ready),
        .wr_data  (in_beat),
        .rd_valid (f_rd_valid),
        .rd_ready (out_ok),
        .rd_data  (f_rd_data),
        .level    (lvl)
      );

      // Buffered beats leave in order when timing allows
      assign out_valid = f_rd_valid & out_ok;
      // Same beat type on both ports, fixed widths
      assign out_beat  = f_rd_data;
      assign lost      = in_valid & ~f_wr_ready;

      late_grant_a : assert property (@(posedge core_clk) disable iff (!rstn)
        in_valid |-> ihist_r[IH-1])
        else $error("upstream beat outside its ready window");
      buf_room_a : assert property (@(posedge core_clk) disable iff (!rstn)
        in_valid |-> f_wr_ready)
        else $error("buffer could not absorb a granted beat");
    end else begin : g_pass
      assign lvl      = '0;
      // Payload untouched from upstream to downstream
      assign out_beat = in_beat;
      if (BOTH) begin : g_pipe
        logic [DH-1:0] rdly_r, rdly_nxt;
        // Ready delayed by the latency difference
        assign rdly_nxt = DH'({rdly_r, out_ready});
        assign in_ready = (DIFF == 0) ? out_ready : rdly_r[DH-1];
        assign out_valid = in_valid;
        assign lost      = 1'b0;
        always_ff @(posedge core_clk or negedge rstn) begin
          if (!rstn) begin
            rdly_r <= '0;
          end else begin
            rdly_r <= rdly_nxt;
          end
        end
        if (DIFF > 0) begin : g_chk
          ready_delay_a : assert property (@(posedge core_clk) disable iff (!rstn)
            out_ready ##DIFF 1'b1 |-> in_ready)
            else $error("upstream ready not delayed by latency difference");
        end
      end else if (!OUT_HAS_READY) begin : g_tie
        // Downstream never stalls
        assign in_ready  = 1'b1;
        assign out_valid = in_valid;
        assign lost      = 1'b0;
      end else begin : g_loss
        // Upstream cannot stall; unusable beats are dropped
        assign in_ready  = 1'b1;
        assign out_valid = in_valid & out_ok;
        assign lost      = in_valid & ~out_ok;
      end
    end
  endgenerate

  // Bus slave: one wait cycle, then answer
  logic                    ack_r, ack_nxt;
  logic [31:0]             rdata_r, rdata_nxt;
  logic                    req;
  logic                    wr_go;

  function automatic logic [31:0] read_mux(input logic [`SRTA_ADDR_W-1:0] a);
    logic [31:0] v;
    v = '0;
    case (a)
      `SRTA_OFF_CTRL:     v[`SRTA_CTRL_ERR_EN] = err_en_r;
      `SRTA_OFF_STATUS: begin
        v[`SRTA_STAT_LOSS] = loss_st_r;
        v[`SRTA_STAT_LVL_LO +: `SRTA_LVL_W] = lvl;
        v[`SRTA_STAT_IN_RDY] = in_ready;
        v[`SRTA_STAT_OUT_VLD] = out_valid;
      end
      `SRTA_OFF_LOSS_CNT: v[`SRTA_CNT_W-1:0] = loss_cnt_r;
      default:            v = '0;
    endcase
    return v;
  endfunction

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;
  assign wr_go           = avs_write & ack_r & avs_byteenable[0];
  assign avs_readdata    = rdata_r;

  always_comb begin
    ack_nxt   = req & ~ack_r;
    rdata_nxt = rdata_r;
    if (avs_read && !ack_r) begin
      rdata_nxt = read_mux(avs_address);
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_r   <= 1'b0;
      rdata_r <= '0;
    end else begin
      ack_r   <= ack_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // Loss flag, counter and pulse; a new loss wins over a clear
  always_comb begin
    err_en_nxt   = err_en_r;
    loss_st_nxt  = loss_st_r;
    loss_cnt_nxt = loss_cnt_r;
    loss_p_nxt   = lost & err_en_r;
    if (wr_go && avs_address == `SRTA_OFF_CTRL) begin
      err_en_nxt = avs_writedata[`SRTA_CTRL_ERR_EN];
    end
    if (wr_go && avs_address == `SRTA_OFF_STATUS && avs_writedata[`SRTA_STAT_LOSS]) begin
      loss_st_nxt = 1'b0;
    end
    if (wr_go && avs_address == `SRTA_OFF_LOSS_CNT) begin
      loss_cnt_nxt = '0;
    end
    if (lost) begin
      loss_st_nxt = 1'b1;
      if (loss_cnt_r != '1) begin
        loss_cnt_nxt = loss_cnt_r + `SRTA_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      err_en_r   <= `SRTA_CTRL_RST;
      loss_st_r  <= 1'b0;
      loss_cnt_r <= '0;
      loss_p_r   <= 1'b0;
    end else begin
      err_en_r   <= err_en_nxt;
      loss_st_r  <= loss_st_nxt;
      loss_cnt_r <= loss_cnt_nxt;
      loss_p_r   <= loss_p_nxt;
    end
  end

  assign loss_err = loss_p_r;

  loss_flag_a : assert property (@(posedge core_clk) disable iff (!rstn)
    lost && err_en_r |=> loss_err && loss_st_r)
    else $error("lost beat not flagged");
  loss_quiet_a : assert property (@(posedge core_clk) disable iff (!rstn)
    !lost |=> !loss_err)
    else $error("loss flagged without a lost beat");
  out_timing_a : assert property (@(posedge core_clk) disable iff (!rstn)
    out_valid |-> out_ok)
    else $error("downstream valid outside its ready window");
  chan_range_a : assert property (@(posedge core_clk) disable iff (!rstn)
    out_valid |-> out_beat.channel <= `SRTA_CH_W'(`SRTA_MAX_CHANNEL))
    else $error("channel above maximum");
  tie_high_a : assert property (@(posedge core_clk) disable iff (!rstn)
    !OUT_HAS_READY |-> in_ready)
    else $error("upstream ready not held high");
  bus_answer_a : assert property (@(posedge core_clk) disable iff (!rstn)
    req && !ack_r |=> !avs_waitrequest || !req)
    else $error("bus request not answered in one wait cycle");
  cnt_step_a : assert property (@(posedge core_clk) disable iff (!rstn)
    lost && !wr_go && loss_cnt_r != '1 |=> loss_cnt_r == $past(loss_cnt_r) + `SRTA_CNT_W'(1))
    else $error("loss counter did not step");
endmodule

/* common/srta_params.svh */
/*
  Constants of the stream ready timing adapter: payload widths, register
  offsets, reset values and buffer depth.
  Assumes inclusion by bare name from the package and the design file.
*/
`ifndef SRTA_PARAMS_SVH
`define SRTA_PARAMS_SVH

`define SRTA_SYM_BITS      8
`define SRTA_SYMS          4
`define SRTA_DATA_W        32
`define SRTA_EMPTY_W       2
`define SRTA_CH_W          4
`define SRTA_MAX_CHANNEL   8'h0F
`define SRTA_ERR_W         1
`define SRTA_FIFO_DEPTH    4
`define SRTA_LVL_W         3

`define SRTA_ADDR_W        4
`define SRTA_OFF_CTRL      4'h0
`define SRTA_OFF_STATUS    4'h4
`define SRTA_OFF_LOSS_CNT  4'h8

`define SRTA_CTRL_ERR_EN   0
`define SRTA_STAT_LOSS     0
`define SRTA_STAT_LVL_LO   4
`define SRTA_STAT_IN_RDY   8
`define SRTA_STAT_OUT_VLD  9
`define SRTA_CTRL_RST      1'h1
`define SRTA_CNT_W         16

`endif

/* common/srta_pkg.sv */
/*
  Types of the stream ready timing adapter.
  Assumes srta_params.svh on the include path.
*/
`include "srta_params.svh"

package srta_pkg;

  typedef struct packed {
    logic [`SRTA_DATA_W-1:0]  data;
    logic [`SRTA_CH_W-1:0]    channel;
    logic [`SRTA_ERR_W-1:0]   error;
    logic                     sop;
    logic                     eop;
    logic [`SRTA_EMPTY_W-1:0] empty;
  } srta_beat_t;

  typedef logic [`SRTA_LVL_W-1:0] srta_lvl_t;
  typedef logic [`SRTA_CNT_W-1:0] srta_cnt_t;

endpackage

/* test/srta_sink_model.sv */
/*
  Downstream sink model: steady, choppy or stalled ready.
  Assumes the adapter output uses a ready latency of one.
*/
`timescale 1ns/1ps
module srta_sink_model (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Bench control
  input  wire logic stall,
  input  wire logic choppy,
  // Stream
  input  wire logic out_valid,
  output logic      out_ready,
  output logic      viol
);
  logic [1:0] cnt_r;
  logic       rdy_r;
  assign out_ready = !stall && (!choppy || cnt_r != 2'h3);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 2'h0;
      rdy_r <= 1'b0;
      viol  <= 1'b0;
    end else begin
      cnt_r <= cnt_r + 2'h1;
      rdy_r <= out_ready;
      // Valid without ready one cycle before
      if (out_valid && !rdy_r) begin
        viol <= 1'b1;
      end
    end
  end
endmodule

/* test/tb_top.sv */
/*
  Testbench of the stream ready timing adapter: buffered and loss modes.
  Assumes the design defaults for the buffered instance.
*/
`timescale 1ns/1ps
module tb_top;
  import srta_pkg::*;
  typedef struct {logic [3:0] a; logic [31:0] d;} srta_row_t;
  logic        core_clk, rstn, in_valid, lv, stall, choppy, sel, chk_en;
  logic        in_ready, out_valid, out_ready, loss_err, ov2, le2, viol, w1, w2;
  srta_beat_t  in_beat, out_beat, ob2;
  logic [3:0]  avs_address, avs_byteenable;
  logic        avs_read, avs_write;
  logic [31:0] avs_writedata, rd1, rd2, rdata;
  logic        rdy_h;
  int          sent, lim, rcv, err_count, checks, k;
  srta_row_t   rows [4] = '{'{4'h0, 32'h1}, '{4'h4, 32'h100}, '{4'h8, 32'h0},
                            '{4'hC, 32'h0}};

  srta_adapter i_srta_adapter (.core_clk(core_clk), .rstn(rstn), .in_valid(in_valid),
    .in_ready(in_ready), .in_beat(in_beat), .out_valid(out_valid), .out_ready(out_ready),
    .out_beat(out_beat), .loss_err(loss_err), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(rd1), .avs_waitrequest(w1));
  // Source without ready
  srta_adapter #(.IN_HAS_READY(1'b0), .IN_RL(0)) i_srta_adapter_loss (
    .core_clk(core_clk), .rstn(rstn), .in_valid(lv), .in_ready(), .in_beat(in_beat),
    .out_valid(ov2), .out_ready(out_ready), .out_beat(ob2), .loss_err(le2),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(rd2), .avs_waitrequest(w2));
  srta_sink_model i_srta_sink_model (.core_clk(core_clk), .rstn(rstn), .stall(stall),
    .choppy(choppy), .out_valid(out_valid), .out_ready(out_ready), .viol(viol));

  function automatic srta_beat_t mk(input int i);
    mk.data  = 32'hA5000000 | i;
    mk.channel = i[3:0];
    mk.error = i[0];
    mk.sop   = (i == 0);
    mk.eop   = (i == 11);
    mk.empty = i[1:0];
  endfunction

  task results;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task tmo;
    err_count++;
    results;
  endtask

  task chk(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask

  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if ((sel ? w2 : w1) === 1'b0) break;
    end
    if (n == 20) tmo;
    rdata = sel ? rd2 : rd1;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  // Lost-beat pulse on the source without ready
  task lose(input logic ok, input logic err);
    @(posedge core_clk) lv <= 1'b1;
    @(posedge core_clk) lv <= 1'b0;
    chk(64'(ov2), 64'(ok));
    if (ok) chk(64'(ob2), 64'(in_beat));
    @(posedge core_clk) chk(64'(le2), 64'(err));
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Upstream source honours its ready latency of two
  always @(posedge core_clk) begin
    rdy_h <= rstn ? in_ready : 1'b0;
    if (rdy_h && sent < lim) begin
      in_valid <= 1'b1;
      in_beat  <= mk(sent);
      sent     <= sent + 1;
    end else begin
      in_valid <= 1'b0;
    end
    if (rstn && chk_en && out_valid) begin
      chk(64'(out_beat), 64'(mk(rcv)));
      rcv <= rcv + 1;
    end
  end

  initial begin
    {rstn, in_valid, lv, choppy, sel, avs_read, avs_write} = '0;
    {stall, chk_en} = 2'h3;
    in_beat = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    rdy_h = 1'b0;
    {sent, lim, rcv, err_count, checks} = '0;
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    foreach (rows[i]) begin
      bus(1'b0, rows[i].a, 32'h0);
      chk(64'(rdata), 64'(rows[i].d));
    end
    // Fill while stalled until refused
    lim = 12;
    for (k = 0; k < 100 && in_ready !== 1'b0; k++) @(posedge core_clk);
    if (k == 100) tmo;
    repeat (6) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(64'(rdata[6:4]), 64'(4));
    stall <= 1'b0;
    choppy <= 1'b1;
    for (k = 0; k < 300 && rcv < 12; k++) @(posedge core_clk);
    if (k == 300) tmo;
    repeat (4) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(64'(rdata[6:4]), 64'(0));
    chk(64'(viol), 64'(0));
    // Loss mode
    sel = 1'b1;
    choppy <= 1'b0;
    lose(1'b1, 1'b0);
    stall <= 1'b1;
    repeat (2) @(posedge core_clk);
    lose(1'b0, 1'b1);
    bus(1'b0, 4'h8, 32'h0);
    chk(64'(rdata), 64'(1));
    bus(1'b1, 4'h4, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk(64'(rdata[0]), 64'(0));
    bus(1'b1, 4'h0, 32'h0);
    lose(1'b0, 1'b0);
    bus(1'b0, 4'h8, 32'h0);
    chk(64'(rdata), 64'(2));
    // Reset with beats buffered
    sel = 1'b0;
    chk_en = 1'b0;
    lim = sent + 3;
    repeat (12) @(posedge core_clk);
    bus(1'b0, 4'h4, 32'h0);
    chk(64'(rdata[6:4]), 64'(3));
    rstn <= 1'b0;
    @(posedge core_clk);
    lim = sent;
    chk(64'({out_valid, loss_err, le2}), 64'(0));
    @(posedge core_clk) rstn <= 1'b1;
    bus(1'b0, 4'h4, 32'h0);
    chk(64'(rdata[6:4]), 64'(0));
    results;
  end
endmodule
